// ---- rtl/tpw_chop_gen.sv ----
// Purpose: 50 percent square wave at a selectable chopping frequency
// Assumes: Half period table from package
// Notes:   Restarts high when run drops
`timescale 1ns/100ps
module tpw_chop_gen
    import tpw_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    tpw_chop_if.gen     cif
);
    logic [7:0] cnt_r;
    logic       sq_r;
    // ==========================================================
    // Square wave divider
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 8'h00;
            sq_r  <= 1'b1;
        end else if (!cif.run) begin
            cnt_r <= 8'h00;
            sq_r  <= 1'b1;
        end else if (cnt_r + 8'h01 >= tpw_chop_half(cif.freq_sel)) begin
            cnt_r <= 8'h00;
            sq_r  <= ~sq_r;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    assign cif.carrier = sq_r;
endmodule : tpw_chop_gen

// ---- rtl/tpw_chop_if.sv ----
// Purpose: Carries chopper settings and carrier between modules
// Assumes: Single clock domain
// Notes:   Config from top, carrier back to top
`timescale 1ns/100ps
interface tpw_chop_if;
    logic [2:0] freq_sel;
    logic       run;
    logic       carrier;
    modport gen  (input freq_sel, input run, output carrier);
    modport user (output freq_sel, output run, input carrier);
endinterface : tpw_chop_if

// ---- rtl/tpw_pkg.sv ----
// Purpose: Shared constants and types for the three-phase PWM generator
// Assumes: 25 MHz peripheral clock
// Notes:   Reset values, field widths and chopper divider table
package tpw_pkg;
    // ==========================================================
    // Widths
    localparam int TPW_CNT_W   = 12;
    localparam int TPW_CMP_W   = 13;
    localparam int TPW_REG_W   = 16;
    localparam int TPW_REP_W   = 8;
    // ==========================================================
    // Reset values
    localparam logic [11:0] TPW_CNT_RST     = 12'h000;
    localparam logic [12:0] TPW_CMP_RST     = 13'h0000;
    localparam logic [11:0] TPW_PER_RST     = 12'hfff;
    localparam logic [2:0]  TPW_PRE_RST     = 3'h0;
    localparam logic [7:0]  TPW_REP_RST     = 8'h00;
    // ==========================================================
    // Chopper field encodings
    localparam logic [1:0]  TPW_CHOP_OFF    = 2'h0;
    localparam logic [1:0]  TPW_CHOP_LOW    = 2'h1;
    localparam logic [1:0]  TPW_CHOP_HIGH   = 2'h2;
    localparam logic [1:0]  TPW_CHOP_BOTH   = 2'h3;
    // Chopper frequencies in kHz at the 16/8 MHz table column
    localparam int TPW_CLK_KHZ = 25000;
    localparam int TPW_CHOP_KHZ [8] = '{100, 200, 400, 500, 800, 1000, 1333, 2000};
    // Half period in cycles, longest time rounds down, at least one
    function automatic logic [7:0] tpw_chop_half(input logic [2:0] sel);
        int c;
        c = TPW_CLK_KHZ / (2 * TPW_CHOP_KHZ[sel]);
        if (c < 1) begin
            c = 1;
        end
        return c[7:0];
    endfunction : tpw_chop_half
    // Counter direction
    typedef enum logic [0:0] {
        TPW_DIR_UP   = 1'b0,
        TPW_DIR_DOWN = 1'b1
    } tpw_dir_t;
endpackage : tpw_pkg

// ---- rtl/tpw_prescale.sv ----
// Purpose: Divide-by-1..8 tick generator for the PWM counter
// Assumes: Divider value changes only at update events
// Notes:   Tick is a one-cycle pulse
`timescale 1ns/100ps
module tpw_prescale (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [2:0] div_sel,
    output logic            tick
);
    logic [2:0] cnt_r;
    // ==========================================================
    // Counts div_sel+1 cycles per tick
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 3'h0;
        end else if (!run || cnt_r == div_sel) begin
            cnt_r <= 3'h0;
        end else begin
            cnt_r <= cnt_r + 3'h1;
        end
    end
    assign tick = run && (cnt_r == div_sel);
endmodule : tpw_prescale

// ---- rtl/tpw_pwm_gen.sv ----
// Purpose: Three-phase PWM generator with carrier period, preload and chopper
// Assumes: Register bits arrive as plain same-clock ports; one 25 MHz clock
// Notes:   Outputs come from flip-flops; compare writes are byte strobes
//
// Summary of operation
// - Two-bit field picks chopped outputs: none, low, high, or both.
// - Three-bit field picks one of eight chopping frequencies.
// - Without deadtime or three-signal routing, roles come from channel assignment; with either, pairs fixed.
// - Three phase outputs share one carrier period, each own duty.
// - Routing bit forwards phase U only, or all three phases.
// - Free-running 12-bit counter, three 13-bit compares, one 12-bit period.
// - Compares have preload copies, transferred at underflow, at overflow, or when enabling.
// - Prescaler divides the clock by any integer from 1 to 8.
// - Prescaler and mode settings apply only after an update event.
// - Center mode counts up to period, down to zero, repeats.
// - Center mode: output low on up match, high on down match.
// - Output held high above extended period, held low at zero compare.
// - Edge mode counts up to period, clears, restarts.
// - Edge mode: output low on up match, high when counter clears.
// - Counter zero-extended to 13 bits meets 13-bit compares.
// - Center mode reloads at both overflow and underflow.
// - Twelve-bit mode: update takes effect only after high byte written.
// - Eight-bit mode: single write, per-phase full-duty bits cleared at update.
// - Reads of buffered registers return the preload contents.
// - Compare bits left-aligned in 16 bits, rounded to 13 bits on load.
// - Period-end transfer only when the 8-bit repetition counter has reached zero; enabling transfers regardless.
// - Counter held at zero while disabled; enabling forces update.
`timescale 1ns/100ps
module tpw_pwm_gen
    import tpw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clk_enable,
    input  wire logic        center_align_sel,
    input  wire logic        short_width_sel,
    input  wire logic [2:0]  counter_prescale_sel,
    input  wire logic [7:0]  repetition_count_reg,
    input  wire logic [2:0]  phase_full_duty_force,
    input  wire logic [3:0]  compare_low_wr,
    input  wire logic [3:0]  compare_high_wr,
    input  wire logic [7:0]  compare_wdata,
    input  wire logic [1:0]  chop_channel_sel,
    input  wire logic [2:0]  chop_freq_sel,
    input  wire logic        three_signal_routing,
    input  wire logic        deadtime_enable,
    input  wire logic [5:0]  channel_polarity_assign_reg,
    output logic [15:0]      preload_rd_u,
    output logic [15:0]      preload_rd_v,
    output logic [15:0]      preload_rd_w,
    output logic [15:0]      preload_rd_period,
    output logic [2:0]       full_duty_rd,
    output logic [11:0]      counter_value,
    output logic [2:0]       phase_pwm,
    output logic [5:0]       motor_drive_output,
    output logic             update_event
);
    // Index 0..2 = U,V,W; 3 = carrier period
    logic [15:0] pre_r     [4];
    logic [7:0]  low_hold_r[4];
    logic [3:0]  pend_r;
    logic [12:0] act_r     [3];
    logic [11:0] per_r;
    logic [2:0]  fdf_pre_r;
    logic [2:0]  fdf_act_r;
    logic        cms_r;
    logic        pms_r;
    logic [2:0]  pcp_r;
    logic [7:0]  rep_r;
    logic [11:0] cnt_r;
    tpw_dir_t    dir_r;
    logic        en_d_r;
    logic [2:0]  ph_r;
    logic [5:0]  mco_r;
    logic        upd_r;
    logic        tick;
    logic        ovf;
    logic        unf;
    logic        upd;
    logic        start;
    logic [12:0] per_ext;
    // ==========================================================
    // Prescaler and chopper
    tpw_prescale u_pre (
        .clk     (clk),
        .rst     (rst),
        .run     (clk_enable),
        .div_sel (pcp_r),
        .tick    (tick)
    );
    tpw_chop_if cif ();
    assign cif.freq_sel = chop_freq_sel;
    assign cif.run      = clk_enable;
    tpw_chop_gen u_chop (
        .clk (clk),
        .rst (rst),
        .cif (cif)
    );
    // ==========================================================
    // Event decode
    assign start = clk_enable && !en_d_r;
    assign ovf   = tick && (cnt_r == per_r) && (dir_r == TPW_DIR_UP);
    assign unf   = tick && cms_r && (cnt_r == 12'h000) && (dir_r == TPW_DIR_DOWN);
    // Center mode counts both turnarounds; edge mode only overflow
    assign upd   = start || ((ovf || unf) && rep_r == 8'h00);
    assign per_ext = {1'b0, per_r};
    // Enable edge tracker
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_d_r <= 1'b0;
        end else begin
            en_d_r <= clk_enable;
        end
    end
    // ==========================================================
    // Preload writes; outside 8-bit mode low byte held until high byte arrives
    for (genvar i = 0; i < 4; i++) begin : g_pre
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                pre_r[i]      <= (i == 3) ? 16'hfff0 : 16'h0000;
                low_hold_r[i] <= 8'h00;
                pend_r[i]     <= 1'b0;
            end else begin
                if (short_width_sel && compare_low_wr[i]) begin
                    // Single access in 8-bit mode
                    pre_r[i] <= {3'h0, compare_wdata, 5'h00};
                    pend_r[i] <= 1'b1;
                end else if (compare_low_wr[i]) begin
                    low_hold_r[i] <= compare_wdata;
                end else if (compare_high_wr[i]) begin
                    pre_r[i]  <= {compare_wdata, low_hold_r[i]};
                    pend_r[i] <= 1'b1;
                end else if (upd) begin
                    pend_r[i] <= 1'b0;
                end
            end
        end
    end
    // Read side shows preload contents only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            preload_rd_u      <= 16'h0000;
            preload_rd_v      <= 16'h0000;
            preload_rd_w      <= 16'h0000;
            preload_rd_period <= 16'hfff0;
            full_duty_rd      <= 3'h0;
        end else begin
            preload_rd_u      <= pre_r[0];
            preload_rd_v      <= pre_r[1];
            preload_rd_w      <= pre_r[2];
            preload_rd_period <= pre_r[3];
            full_duty_rd      <= fdf_pre_r;
        end
    end
    // ==========================================================
    // Full-duty force bits: software sets, update clears
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fdf_pre_r <= 3'h0;
        end else if (|phase_full_duty_force) begin
            fdf_pre_r <= fdf_pre_r | phase_full_duty_force; // set wins over clear
        end else if (upd) begin
            fdf_pre_r <= 3'h0;
        end
    end
    // ==========================================================
    // Rounded 13-bit load from left-aligned word
    function automatic logic [12:0] tpw_round(input logic [15:0] v);
        logic [13:0] s;
        s = {1'b0, v[15:3]} + {13'h0000, v[2]};
        return s[13] ? 13'h1fff : s[12:0];
    endfunction : tpw_round
    // Active transfer at update event
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int k = 0; k < 3; k++) begin
                act_r[k] <= TPW_CMP_RST;
            end
            per_r     <= TPW_PER_RST;
            fdf_act_r <= 3'h0;
            cms_r     <= 1'b0;
            pms_r     <= 1'b0;
            pcp_r     <= TPW_PRE_RST;
        end else if (upd) begin
            for (int k = 0; k < 3; k++) begin
                act_r[k] <= tpw_round(pre_r[k]);
            end
            per_r     <= tpw_round(pre_r[3])[11:0];
            fdf_act_r <= fdf_pre_r;
            cms_r     <= center_align_sel;
            pms_r     <= short_width_sel;
            pcp_r     <= counter_prescale_sel;
        end
    end
    // ==========================================================
    // Repetition down-counter, auto-reload
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rep_r <= TPW_REP_RST;
        end else if (upd) begin
            rep_r <= repetition_count_reg;
        end else if (ovf || unf) begin
            rep_r <= rep_r - 8'h01;
        end
    end
    // ==========================================================
    // PWM counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= TPW_CNT_RST;
            dir_r <= TPW_DIR_UP;
        end else if (!clk_enable || start) begin
            cnt_r <= TPW_CNT_RST;
            dir_r <= TPW_DIR_UP;
        end else if (tick) begin
            if (!cms_r) begin
                dir_r <= TPW_DIR_UP;
                cnt_r <= (cnt_r >= per_r) ? 12'h000 : cnt_r + 12'h001;
            end else if (dir_r == TPW_DIR_UP) begin
                if (cnt_r >= per_r) begin
                    dir_r <= TPW_DIR_DOWN;
                    cnt_r <= cnt_r - 12'h001;
                end else begin
                    cnt_r <= cnt_r + 12'h001;
                end
            end else begin
                if (cnt_r == 12'h000) begin
                    // Turn at zero so both half periods have equal length
                    dir_r <= TPW_DIR_UP;
                    cnt_r <= 12'h001;
                end else begin
                    cnt_r <= cnt_r - 12'h001;
                end
            end
        end
    end
    // ==========================================================
    // Phase compare logic per phase
    for (genvar p = 0; p < 3; p++) begin : g_ph
        logic [12:0] cmp;
        assign cmp = pms_r ? (fdf_act_r[p] ? 13'h1fff : act_r[p]) : act_r[p];
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                ph_r[p] <= 1'b0;
            end else if (cmp == 13'h0000) begin
                ph_r[p] <= 1'b0;
            end else if (cmp > per_ext) begin
                ph_r[p] <= 1'b1;
            end else if (!clk_enable) begin
                ph_r[p] <= 1'b1;
            end else if (tick && cms_r && dir_r == TPW_DIR_UP && {1'b0, cnt_r} == cmp) begin
                ph_r[p] <= 1'b0;
            end else if (tick && !cms_r && cnt_r < per_r
                         && ({1'b0, cnt_r} + 13'h0001) == cmp) begin
                ph_r[p] <= 1'b0;
            end else if (tick && cms_r && dir_r == TPW_DIR_DOWN
                         && {1'b0, cnt_r} == cmp) begin
                ph_r[p] <= 1'b1;
            end else if (tick && !cms_r && cnt_r >= per_r) begin
                ph_r[p] <= 1'b1;
            end
        end
    end
    // ==========================================================
    // Routing and chopping onto the six drive outputs
    logic [5:0] mco_nxt;
    always_comb begin
        logic [2:0] src;
        logic [5:0] hi_mask;
        hi_mask = 6'h00;
        src = three_signal_routing ? ph_r : {3{ph_r[0]}};
        if (three_signal_routing || deadtime_enable) begin
            hi_mask = 6'h15;
        end else begin
            hi_mask = channel_polarity_assign_reg;
        end
        for (int c = 0; c < 6; c++) begin
            if (three_signal_routing || deadtime_enable) begin
                mco_nxt[c] = c[0] ? ~src[c/2] : src[c/2];
            end else begin
                mco_nxt[c] = src[c/2];
            end
            if (mco_nxt[c] && ((hi_mask[c] && chop_channel_sel[1])
                               || (!hi_mask[c] && chop_channel_sel[0]))) begin
                mco_nxt[c] = cif.carrier;
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mco_r <= 6'h00;
            upd_r <= 1'b0;
        end else begin
            mco_r <= clk_enable ? mco_nxt : 6'h00;
            upd_r <= upd;
        end
    end
    assign motor_drive_output = mco_r;
    assign phase_pwm          = ph_r;
    assign counter_value      = cnt_r;
    assign update_event       = upd_r;
    // ==========================================================
    // Checks
    sequence s_enable_rise;
        clk_enable && !$past(clk_enable);
    endsequence
    a_start_update: assert property (@(posedge clk) disable iff (rst)
        s_enable_rise |=> update_event) else $error("no update at enable");
    a_idle_zero: assert property (@(posedge clk) disable iff (rst)
        !clk_enable |=> counter_value == 12'h000) else $error("counter not held");
    a_update_rep: assert property (@(posedge clk) disable iff (rst)
        (upd && !start) |-> (rep_r == 8'h00)) else $error("update with rep");
    a_zero_low: assert property (@(posedge clk) disable iff (rst)
        (act_r[0] == 13'h0000 && !pms_r) |=> !phase_pwm[0]) else $error("zero not low");
    a_edge_wrap: assert property (@(posedge clk) disable iff (rst)
        (clk_enable && !cms_r && tick && cnt_r == per_r && !start)
        |=> counter_value == 12'h000) else $error("edge no wrap");
    a_center_turn: assert property (@(posedge clk) disable iff (rst)
        (clk_enable && cms_r && tick && cnt_r == per_r && per_r != 12'h000 && !upd)
        |=> dir_r == TPW_DIR_DOWN) else $error("no turn");
    a_cfg_hold: assert property (@(posedge clk) disable iff (rst)
        !upd |=> $stable(pcp_r)) else $error("prescale changed");
    a_preload_rd: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> preload_rd_u == $past(pre_r[0])) else $error("read not preload");
endmodule : tpw_pwm_gen

// ---- testbench/tpw_drive_mon.sv ----
// Purpose: Channel manager stand-in that tallies drive output high time
// Assumes: Drive outputs sampled on rising clk
// Notes:   Tallies restart while clr is high
`timescale 1ns/100ps
module tpw_drive_mon (
    input  wire logic       clk,
    input  wire logic       clr,
    input  wire logic [5:0] motor_drive_output,
    output int              hi_cnt [6]
);
    // ==========================================================
    // High-time tally per switch
    always_ff @(posedge clk) begin
        for (int i = 0; i < 6; i++) begin
            if (clr) begin
                hi_cnt[i] <= 0;
            end else begin
                hi_cnt[i] <= hi_cnt[i] + int'(motor_drive_output[i]);
            end
        end
    end
endmodule : tpw_drive_mon

// ---- testbench/tpw_pwm_gen_test.sv ----
// Purpose: Self-checking bench for the three-phase PWM generator
// Assumes: Period 8, no repetition, three-signal routing, no deadtime
// Notes:   Duty and chop measured as high-time counts over whole periods
`timescale 1ns/100ps
module tpw_pwm_gen_test
    import tpw_pkg::*;
;
    logic        clk, rst, clk_enable, center_align_sel, short_width_sel, mon_clr;
    logic        three_signal_routing, deadtime_enable, update_event;
    logic [2:0]  counter_prescale_sel, phase_full_duty_force, chop_freq_sel;
    logic [2:0]  full_duty_rd, phase_pwm;
    logic [7:0]  repetition_count_reg, compare_wdata;
    logic [3:0]  compare_low_wr, compare_high_wr;
    logic [1:0]  chop_channel_sel;
    logic [5:0]  channel_polarity_assign_reg, motor_drive_output;
    logic [15:0] preload_rd_u, preload_rd_v, preload_rd_w, preload_rd_period;
    logic [11:0] counter_value;
    int          hi_cnt [6];
    int          ph [3];
    int          miscompares, n_checks, cyc, cmax, g;
    // ==========================================================
    // Design and far-side model
    tpw_pwm_gen tpw_pwm_gen_i (.clk, .rst, .clk_enable, .center_align_sel, .short_width_sel,
        .counter_prescale_sel, .repetition_count_reg, .phase_full_duty_force,
        .compare_low_wr, .compare_high_wr, .compare_wdata, .chop_channel_sel,
        .chop_freq_sel, .three_signal_routing, .deadtime_enable,
        .channel_polarity_assign_reg, .preload_rd_u, .preload_rd_v, .preload_rd_w,
        .preload_rd_period, .full_duty_rd, .counter_value, .phase_pwm,
        .motor_drive_output, .update_event);
    tpw_drive_mon tpw_drive_mon_i (.clk, .clr(mon_clr), .motor_drive_output, .hi_cnt);
    // ==========================================================
    // Clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            $display("BAD t=%0t timeout", $time);
            wrap_up();
        end
    end
    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // One byte strobe; low byte first keeps the pair ordered
    task automatic wb(input bit hi, input int idx, input logic [7:0] d);
        @(posedge clk);
        if (hi) begin
            compare_high_wr[idx] <= 1'b1;
        end else begin
            compare_low_wr[idx] <= 1'b1;
        end
        compare_wdata <= d;
        @(posedge clk);
        compare_low_wr <= 4'h0;
        compare_high_wr <= 4'h0;
    endtask : wb
    task automatic wr(input int idx, input logic [15:0] w);
        wb(1'b0, idx, w[7:0]);
        wb(1'b1, idx, w[15:8]);
    endtask : wr
    task automatic wait_upd();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (update_event !== 1'b1 && k < 400);
        if (k >= 400) begin
            chk(0, 1, "no update");
        end
    endtask : wait_upd
    task automatic upd_gap(output int n);
        wait_upd();
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (update_event !== 1'b1 && n < 400);
    endtask : upd_gap
    // Tally phase high time and counter peak over n cycles
    task automatic win(input int n);
        @(posedge clk);
        mon_clr <= 1'b1;
        @(posedge clk);
        mon_clr <= 1'b0;
        ph = '{0, 0, 0};
        cmax = 0;
        repeat (n) begin
            @(posedge clk);
            for (int i = 0; i < 3; i++) begin
                ph[i] += int'(phase_pwm[i]);
            end
            if (int'(counter_value) > cmax) begin
                cmax = int'(counter_value);
            end
        end
        #1;
    endtask : win
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    // ==========================================================
    // Test sequence
    initial begin
        int expd [6];
        expd = '{32, 40, 72, 0, 0, 72};
        clk = 1'b0;
        {miscompares, n_checks, cyc} = '0;
        rst <= 1'b1;
        {clk_enable, center_align_sel, short_width_sel, mon_clr, deadtime_enable} <= '0;
        three_signal_routing <= 1'b1;
        {counter_prescale_sel, phase_full_duty_force, chop_freq_sel} <= '0;
        {repetition_count_reg, compare_wdata, compare_low_wr, compare_high_wr} <= '0;
        chop_channel_sel <= 2'h0;
        channel_polarity_assign_reg <= 6'h15;
        tick(2);
        rst <= 1'b0;
        tick(4);
        chk(counter_value, 0, "idle counter");
        chk(motor_drive_output, 0, "idle drive");
        chk(preload_rd_period, 16'hfff0, "period reset");
        $display("reset test done");
        wr(3, 16'h0040);
        wr(0, 16'h0020);
        wr(1, 16'h0048);
        wr(2, 16'h0000);
        tick(2);
        chk(preload_rd_period, 16'h0040, "period preload");
        chk(preload_rd_u, 16'h0020, "u preload");
        chk(preload_rd_v, 16'h0048, "v preload");
        clk_enable <= 1'b1;
        wait_upd();
        tick(10);
        win(72);
        chk(ph[0], 32, "u duty");
        chk(ph[1], 72, "v full");
        chk(ph[2], 0, "w zero");
        chk(cmax, 8, "edge peak");
        for (int i = 0; i < 6; i++) begin
            chk(hi_cnt[i], expd[i], "drive tally");
        end
        $display("edge test done");
        for (int p = 0; p < 8; p++) begin
            counter_prescale_sel <= 3'(p);
            upd_gap(g);
            upd_gap(g);
            chk(g, 9 * (p + 1), "update gap");
        end
        $display("prescale test done");
        wb(1'b0, 0, 8'h50);
        tick(3);
        chk(preload_rd_u, 16'h0020, "low byte alone");
        wb(1'b1, 0, 8'h00);
        tick(2);
        chk(preload_rd_u, 16'h0050, "pair done");
        upd_gap(g);
        win(72);
        chk(ph[0], 72, "new duty");
        $display("preload test done");
        for (int s = 0; s < 8; s++) begin
            chop_channel_sel <= 2'(s / 2);
            chop_freq_sel <= (s % 2 == 1) ? 3'h7 : 3'h5;
            tick(30);
            win(72);
            chk(hi_cnt[2], (s / 2 >= 2) ? 36 : 72, "even chop");
            chk(hi_cnt[5], (s / 2 % 2 == 1) ? 36 : 72, "odd chop");
        end
        $display("chop test done");
        chop_channel_sel <= 2'h0;
        center_align_sel <= 1'b1;
        counter_prescale_sel <= 3'h0;
        upd_gap(g);
        upd_gap(g);
        chk(g, 8, "center gap");
        win(64);
        chk(cmax, 8, "center peak");
        chk(ph[1], 64, "center v");
        chk(ph[2], 0, "center w");
        $display("center test done");
        short_width_sel <= 1'b1;
        wait_upd();
        phase_full_duty_force <= 3'h4;
        @(posedge clk);
        phase_full_duty_force <= 3'h0;
        tick(2);
        chk(full_duty_rd, 3'h4, "force set");
        wait_upd();
        tick(2);
        chk(full_duty_rd, 3'h0, "force clear");
        $display("force test done");
        wrap_up();
    end
endmodule : tpw_pwm_gen_test
